// [common/gpp_map.vh]
`ifndef GPP_MAP_VH
`define GPP_MAP_VH

// Register indices; byte address is four times the index
`define GPP_IDX_DIR          32'h0008c001
`define GPP_IDX_OUT_LATCH    32'h0008c021
`define GPP_IDX_READBACK     32'h0008c041
`define GPP_IDX_FUNC_SEL     32'h0008c061
`define GPP_IDX_OTYPE_LOW    32'h0008c082
`define GPP_IDX_OTYPE_LOW_E  32'h0008c09c

// Reset values
`define GPP_RST_DIR          8'h00
`define GPP_RST_OUT_LATCH    8'h00
`define GPP_RST_FUNC_SEL     8'h00
`define GPP_RST_OTYPE_LOW    8'h00

// Field positions
`define GPP_P3_INONLY_BIT    5
`define GPP_PE1_TYPE_HI_BIT  3
`define GPP_PE1_TYPE_LO_BIT  2

// Output type codes per pin
`define GPP_TYPE_CMOS        2'h0
`define GPP_TYPE_NMOS_OD     2'h1
`define GPP_TYPE_PMOS_OD     2'h2

// Pin synchroniser depth
`define GPP_SYNC_STAGES      2

`endif

// [rtl/gpp_pad.v]
`include "gpp_map.vh"
`default_nettype none

module gpp_pad #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input  wire               hclk,
   input  wire               hresetn,
   input  wire               ce,
   // Per-pin request
   input  wire [WIDTH-1:0]   drv_en,
   input  wire [WIDTH-1:0]   drv_data,
   input  wire [2*WIDTH-1:0] drv_type,
   // Pad side
   output wire [WIDTH-1:0]   pin_out,
   output wire [WIDTH-1:0]   pin_oe
);

   reg [WIDTH-1:0] out_ff;
   reg [WIDTH-1:0] oe_ff;
   reg [WIDTH-1:0] nxt_out;
   reg [WIDTH-1:0] nxt_oe;
   integer         i;

   // Open-drain types drive only one level and release the pin otherwise
   always @*
   begin
      nxt_out = {WIDTH{1'b0}};
      nxt_oe  = {WIDTH{1'b0}};
      for (i = 0; i < WIDTH; i = i + 1)
      begin
         case (drv_type[2*i +: 2])
            `GPP_TYPE_NMOS_OD:
            begin
               nxt_out[i] = 1'b0;
               nxt_oe[i]  = drv_en[i] & ~drv_data[i];
            end
            `GPP_TYPE_PMOS_OD:
            begin
               nxt_out[i] = 1'b1;
               nxt_oe[i]  = drv_en[i] & drv_data[i];
            end
            default:
            begin
               nxt_out[i] = drv_data[i];
               nxt_oe[i]  = drv_en[i];
            end
         endcase
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         out_ff <= {WIDTH{1'b0}};
         oe_ff  <= {WIDTH{1'b0}};
      end
      else if (ce)
      begin
         out_ff <= nxt_out;
         oe_ff  <= nxt_oe;
      end
   end

   assign pin_out = out_ff;
   assign pin_oe  = oe_ff;

endmodule

`default_nettype wire

// [rtl/gpp_port.v]
// What this block does
// - After reset every pin is an input with its driver off.
// - Each direction bit steers one general I/O pin: 0 input, 1 output.
// - Port 3 pin 5 is input only; its driver is never enabled.
// - Each output latch bit sets its pin level: 0 low, 1 high.
// - Reserved output latch bits, port 3 pin 5 included, never drive a pin.
// - Readback returns every pin's current level whatever direction or function.
// - Port 3 readback bit 5 shows the non-maskable interrupt pin level.
// - With analog select set, the readback bit is not a valid pin level.
// - Reserved readback bits are undefined and writes cannot change them.
// - Each function bit picks general I/O (0) or peripheral (1) for one pin.
// - Function bits of missing pins read 0; software writes 0 to them.
// - Even bits of the low output-type register pick CMOS or NMOS for pins 0-3.
// - Port E pin 1 uses bits 3:2: CMOS, NMOS, PMOS; value 3 prohibited.
// - Odd output-type bits are reserved except bit 3 on port E.
// - Reserved and missing-pin output-type bits read 0; software writes 0.
`include "gpp_map.vh"
`default_nettype none

module gpp_port #(
   parameter [7:0] IMPL_MASK = 8'hff,
   parameter       IS_PORT3  = 0,
   parameter       IS_PORT_E = 0
) (
   // Clock, reset, enable
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        ce,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output wire        hreadyout,
   output wire        hresp,
   output wire [31:0] hrdata,
   // Package pins
   input  wire [7:0]  pin_in,
   input  wire        nmi_pin,
   output wire [7:0]  pin_out,
   output wire [7:0]  pin_oe,
   // Peripheral modules and pin function config
   input  wire [7:0]  periph_out,
   input  wire [7:0]  periph_oe,
   input  wire [7:0]  analog_select,
   output wire [7:0]  periph_in
);

   localparam [31:0] ADDR_DIR       = `GPP_IDX_DIR << 2;
   localparam [31:0] ADDR_OUT_LATCH = `GPP_IDX_OUT_LATCH << 2;
   localparam [31:0] ADDR_READBACK  = `GPP_IDX_READBACK << 2;
   localparam [31:0] ADDR_FUNC_SEL  = `GPP_IDX_FUNC_SEL << 2;
   localparam [31:0] ADDR_OTYPE     = (IS_PORT_E != 0) ? (`GPP_IDX_OTYPE_LOW_E << 2) :
                                                         (`GPP_IDX_OTYPE_LOW << 2);

   localparam [7:0] P3_MASK  = (IS_PORT3 != 0) ? (8'h01 << `GPP_P3_INONLY_BIT) : 8'h00;
   localparam [7:0] DRV_MASK = IMPL_MASK & ~P3_MASK;
   localparam       PE_HI    = (IS_PORT_E != 0) ? 1 : 0;
   localparam [7:0] OT_MASK  = {1'b0, IMPL_MASK[3], 1'b0, IMPL_MASK[2],
                                (PE_HI == 1) & IMPL_MASK[1], IMPL_MASK[1],
                                1'b0, IMPL_MASK[0]};

   // Register state
   reg [7:0]  dir_ff;
   reg [7:0]  latch_ff;
   reg [7:0]  func_ff;
   reg [7:0]  otype_ff;
   reg [7:0]  nxt_dir;
   reg [7:0]  nxt_latch;
   reg [7:0]  nxt_func;
   reg [7:0]  nxt_otype;

   // Bus data phase state
   reg        wr_pend_ff;
   reg [31:0] waddr_ff;
   reg [31:0] rdata_ff;
   reg [31:0] nxt_rdata;

   wire       addr_take;
   wire       wr_now;
   wire [7:0] pin_sync;
   wire       nmi_sync;
   reg  [7:0] readback;
   wire [7:0] drv_en;
   wire [7:0] drv_data;
   wire [15:0] drv_type;

   // Stalls the master while the enable freezes state
   assign hreadyout = ce;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_ff;

   assign addr_take = hsel & hready & htrans[1] & ce;
   assign wr_now    = wr_pend_ff & ce;

   gpp_sync #(
      .WIDTH (9)
   ) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .ce       (ce),
      .async_in ({nmi_pin, pin_in}),
      .sync_out ({nmi_sync, pin_sync})
   );

   assign periph_in = pin_sync;

   // Write decode; next values also feed the read mux so read-after-write sees new data
   always @*
   begin
      nxt_dir   = dir_ff;
      nxt_latch = latch_ff;
      nxt_func  = func_ff;
      nxt_otype = otype_ff;
      if (wr_now)
      begin
         // missing-pin direction bits accepted as written
         if (waddr_ff == ADDR_DIR)
            nxt_dir = hwdata[7:0];
         if (waddr_ff == ADDR_OUT_LATCH)
            nxt_latch = hwdata[7:0] & DRV_MASK;
         if (waddr_ff == ADDR_FUNC_SEL)
            nxt_func = hwdata[7:0] & IMPL_MASK;
         // odd type bits kept only where functional
         if (waddr_ff == ADDR_OTYPE)
            nxt_otype = hwdata[7:0] & OT_MASK;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dir_ff   <= `GPP_RST_DIR;
         latch_ff <= `GPP_RST_OUT_LATCH;
         func_ff  <= `GPP_RST_FUNC_SEL;
         otype_ff <= `GPP_RST_OTYPE_LOW;
      end
      else if (ce)
      begin
         dir_ff   <= nxt_dir;
         latch_ff <= nxt_latch;
         func_ff  <= nxt_func;
         otype_ff <= nxt_otype;
      end
   end

   // Pin level readback
   always @*
   begin
      // synchronised level regardless of direction and function
      readback = pin_sync;
      // non-maskable interrupt level on port 3 bit 5
      if (IS_PORT3 != 0)
         readback[`GPP_P3_INONLY_BIT] = nmi_sync;
      // analog pins read as 0, not a level
      // reserved bits have no storage and read 0
      readback = readback & ~analog_select & IMPL_MASK;
   end

   // Read mux; unmapped addresses read 0
   always @*
   begin
      nxt_rdata = 32'h0000_0000;
      if (haddr == ADDR_DIR)
         nxt_rdata[7:0] = nxt_dir;
      else if (haddr == ADDR_OUT_LATCH)
         nxt_rdata[7:0] = nxt_latch;
      else if (haddr == ADDR_READBACK)
         nxt_rdata[7:0] = readback;
      else if (haddr == ADDR_FUNC_SEL)
         nxt_rdata[7:0] = nxt_func;
      else if (haddr == ADDR_OTYPE)
         nxt_rdata[7:0] = nxt_otype;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_ff <= 1'b0;
         waddr_ff   <= 32'h0000_0000;
         rdata_ff   <= 32'h0000_0000;
      end
      else if (ce)
      begin
         wr_pend_ff <= addr_take & hwrite;
         if (addr_take)
            waddr_ff <= haddr;
         if (addr_take & ~hwrite)
            rdata_ff <= nxt_rdata;
      end
   end

   // Driver request per pin
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_pin
         // general mode uses the latch, peripheral mode the peripheral
         // direction bit enables the general output
         // input-only pin and missing pins never drive
         assign drv_en[g]   = DRV_MASK[g] &
                              (func_ff[g] ? periph_oe[g] : dir_ff[g]);
         // latch bit is the driven level
         assign drv_data[g] = func_ff[g] ? periph_out[g] : latch_ff[g];
         if (g < 4)
         begin : g_low
            if ((IS_PORT_E != 0) && (g == 1))
            begin : g_pe1
               // two-bit type, prohibited code falls back to CMOS
               assign drv_type[2*g +: 2] =
                  ({otype_ff[`GPP_PE1_TYPE_HI_BIT], otype_ff[`GPP_PE1_TYPE_LO_BIT]} == 2'h3) ?
                  `GPP_TYPE_CMOS :
                  {otype_ff[`GPP_PE1_TYPE_HI_BIT], otype_ff[`GPP_PE1_TYPE_LO_BIT]};
            end
            else
            begin : g_even
               assign drv_type[2*g +: 2] = {1'b0, otype_ff[2*g]};
            end
         end
         else
         begin : g_high
            // Upper pins have no type control here and stay CMOS
            assign drv_type[2*g +: 2] = `GPP_TYPE_CMOS;
         end
      end
   endgenerate

   gpp_pad #(
      .WIDTH (8)
   ) u_pad (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .ce       (ce),
      .drv_en   (drv_en),
      .drv_data (drv_data),
      .drv_type (drv_type),
      .pin_out  (pin_out),
      .pin_oe   (pin_oe)
   );

endmodule

`default_nettype wire

// [rtl/gpp_sync.v]
`include "gpp_map.vh"
`default_nettype none

module gpp_sync #(
   parameter WIDTH = 9
) (
   // Clock and reset
   input  wire             hclk,
   input  wire             hresetn,
   input  wire             ce,
   // Asynchronous levels and their synchronised copies
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   // First stage feeds only the second stage
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
      end
      else if (ce)
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

`default_nettype wire

// [verif/gpp_pin_env.sv]
`default_nettype none
module gpp_pin_env (
   // Pad side of the port
   input wire logic [7:0]  pin_out,
   input wire logic [7:0]  pin_oe,
   // Board levels and resolved wire
   input wire logic [7:0]  ext_level,
   output logic [7:0]      pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// [verif/gpp_port_checker.sv]
`default_nettype none
`include "gpp_map.vh"
module gpp_port_chk #(
   parameter IS_PORT3 = 0
) (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        ce,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Pins and peripherals
   input wire logic [7:0]  pin_in,
   input wire logic        nmi_pin,
   input wire logic [7:0]  pin_out,
   input wire logic [7:0]  pin_oe,
   input wire logic [7:0]  analog_select,
   input wire logic [7:0]  periph_in
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   wire       rd_go;
   wire [7:0] pin_view;
   assign rd_go = hsel && hready && htrans[1] && !hwrite && ce;
   assign pin_view = IS_PORT3 ? {pin_in[7:6], nmi_pin, pin_in[4:0]} : pin_in;
   sequence s_quiet;
      ce && $stable(pin_in) && $stable(nmi_pin) && analog_select == 8'h00;
   endsequence
   sequence s_rd_pins;
      rd_go && haddr == `GPP_IDX_READBACK * 4;
   endsequence
   property p_pin_read;
      s_quiet [*4] ##0 s_rd_pins |=> hrdata[7:0] == $past(pin_view);
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("readback differs from pins");
   property p_sync;
      s_quiet [*4] |-> ((periph_in ^ pin_in) & 8'hdf) == 8'h00;
   endproperty
   a_sync: assert property (p_sync) else $error("periph_in differs from pins");
   property p_in_only;
      !IS_PORT3 || !pin_oe[5];
   endproperty
   a_in_only: assert property (p_in_only) else $error("input-only pin driven");
   property p_release;
      $rose(hresetn) |-> pin_oe == 8'h00;
   endproperty
   a_release: assert property (p_release) else $error("driver on after reset");
   property p_ready;
      hreadyout == ce;
   endproperty
   a_ready: assert property (p_ready) else $error("hreadyout not ce");
   property p_okay;
      hresp == 1'b0 && hrdata[31:8] == 24'h0;
   endproperty
   a_okay: assert property (p_okay) else $error("bad response or upper data");
   property p_hold;
      !rd_go |=> $stable(hrdata);
   endproperty
   a_hold: assert property (p_hold) else $error("hrdata moved without read");
   property p_freeze;
      !ce |=> $stable(pin_oe) && $stable(pin_out) && $stable(periph_in);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while stalled");
endmodule
bind gpp_port gpp_port_chk #(.IS_PORT3(IS_PORT3)) u_chk (.*);
`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none
`include "gpp_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_DIR = `GPP_IDX_DIR * 4;
   localparam logic [31:0] A_OUT = `GPP_IDX_OUT_LATCH * 4;
   localparam logic [31:0] A_RB  = `GPP_IDX_READBACK * 4;
   localparam logic [31:0] A_FN  = `GPP_IDX_FUNC_SEL * 4;
   localparam logic [31:0] A_OT  = `GPP_IDX_OTYPE_LOW * 4;
   localparam logic [31:0] A_OTE = `GPP_IDX_OTYPE_LOW_E * 4;
   logic            hclk, hresetn, ce, hsel, hwrite, nmi_pin;
   logic [31:0]     haddr, hwdata, rd;
   logic [1:0]      htrans;
   logic [7:0]      ext_level, periph_out, periph_oe, analog_select;
   wire logic       hreadyout, hresp;
   wire logic [31:0] hrdata;
   wire logic [7:0] pin_in, pin_out, pin_oe, periph_in;
   int              n_mismatch, samples_checked;
   logic [31:0]     regs [5] = '{A_DIR, A_OUT, A_FN, A_OT, A_OTE};

   gpp_port #(.IS_PORT3(1)) uut (.hready(hreadyout), .hsize(3'h2), .*);
   gpp_pin_env env (.*);

   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Bounded wait for an edge with hready high
   task automatic wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1)
      begin
         n_mismatch++;
         wrap_up;
      end
   endtask

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask

   // Covers pad register and two-stage pin sync
   task automatic settle;
      repeat (4) @(posedge hclk);
   endtask

   initial
   begin
      {hresetn, hsel, hwrite, htrans, nmi_pin} = '0;
      {haddr, hwdata, periph_out, periph_oe, analog_select} = '0;
      ce = 1'b1;
      ext_level = 8'h3c;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      chk("oe_reset", 32'h0, pin_oe);
      foreach (regs[i])
      begin
         ahb(1'b0, regs[i], 32'h0);
         chk("reg_reset", 32'h0, rd);
      end
      // Input-only bit 5 gets ones
      ahb(1'b1, A_DIR, 32'hff);
      ahb(1'b1, A_OUT, 32'ha5);
      settle;
      chk("oe_gpio", 32'hdf, pin_oe);
      chk("out_gpio", 32'h85, pin_out & pin_oe);
      nmi_pin <= 1'b1;
      analog_select <= 8'h01;
      settle;
      ahb(1'b1, A_RB, 32'h0);
      ahb(1'b0, A_RB, 32'h0);
      chk("rb_out", 32'ha4, rd & 32'hfffffffe);
      nmi_pin <= 1'b0;
      analog_select <= 8'h00;
      ahb(1'b1, A_DIR, 32'h0);
      settle;
      ahb(1'b0, A_RB, 32'h0);
      chk("rb_in", 32'h1c, rd);
      ahb(1'b1, A_DIR, 32'hff);
      ahb(1'b1, A_FN, 32'h0f);
      periph_oe <= 8'h03;
      periph_out <= 8'h01;
      ahb(1'b0, A_FN, 32'h0);
      chk("func", 32'h0f, rd);
      settle;
      chk("oe_periph", 32'hd3, pin_oe);
      chk("out_periph", 32'h81, pin_out & pin_oe);
      ahb(1'b1, A_FN, 32'h0);
      ahb(1'b1, A_OT, 32'hff);
      ahb(1'b0, A_OT, 32'h0);
      chk("otype", 32'h55, rd);
      settle;
      chk("oe_od", 32'hda, pin_oe);
      chk("out_od", 32'h80, pin_out & pin_oe);
      ce <= 1'b0;
      fork
         ahb(1'b0, A_DIR, 32'h0);
         begin
            repeat (3) @(posedge hclk);
            ce <= 1'b1;
         end
      join
      chk("stalled_read", 32'hff, rd);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, A_DIR, 32'h0);
      chk("dir_rereset", 32'h0, rd);
      chk("oe_rereset", 32'h0, pin_oe);
      wrap_up;
   end
endmodule
`default_nettype wire
